// >>> hw/rasc_ctrl.sv
module rasc_ctrl #(
  parameter int TG_DIV = rasc_pkg::TG_DIV_DEFAULT,
  parameter int CLEAR_TICKS = rasc_pkg::CLEAR_TICKS_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic done_program_pin_i,
  output logic done_program_pin_o,
  output logic done_program_pin_oe_n,
  output logic done_pullup_en,
  input wire logic config_load_done,
  input wire logic osc_in,
  output logic osc_out,
  output logic config_clock,
  output logic mem_clear,
  output logic clear_complete_indication,
  output logic user_output_enable,
  output logic io_pullup_en,
  output logic internal_reset
);

  // apb state
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  rasc_pkg::rasc_opts_t opts_q;
  // timing generator
  logic [$clog2(TG_DIV)-1:0] tg_cnt_q;
  logic tick;
  logic config_clock_q;
  // pin synchroniser and request filter
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic [1:0] low_cnt_q;
  logic req_ok;
  // sequencer
  rasc_pkg::rasc_state_t state_q;
  logic [$clog2(CLEAR_TICKS+1)-1:0] clr_cnt_q;
  logic [1:0] step_q;
  logic [1:0] step_d;
  logic clr_done_q;
  logic oe_q;
  logic oe_d;
  logic done_q;
  logic rst_q;
  // oscillator path
  logic osc_meta_q;
  logic osc_sync_q;
  logic osc_prev_q;
  logic osc_q;
  logic apb_acc;

  // access phase; pready is already high in its first cycle, so no wait state
  assign apb_acc = psel & penable & pready_q;

  // decode serves the error path only; the read path compares the offsets itself
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == rasc_pkg::OFS_OPTIONS) || (a == rasc_pkg::OFS_STATUS);
  endfunction

  // pready rises one cycle after setup, so every access is two cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_q <= 1'b0;
    else
      pready_q <= psel & ~penable;
  end

  // read data and error are captured at setup so they stand with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (psel & ~penable)
    begin
      pslverr_q <= ~addr_ok(paddr);
      if (!pwrite && paddr == rasc_pkg::OFS_OPTIONS)
        prdata_q <= {28'h000_0000, opts_q};
      else if (!pwrite && paddr == rasc_pkg::OFS_STATUS)
        prdata_q <= {22'h00_0000, state_q, pin_sync_q, done_q, rst_q, oe_q,
                     clr_done_q, osc_q, config_clock_q, mem_clear};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // option bits stand in for the configuration bit stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opts_q <= rasc_pkg::OPT_RESET;
    else if (apb_acc && pwrite && paddr == rasc_pkg::OFS_OPTIONS)
      opts_q <= pwdata[3:0];
  end

  // internal timing generator; tick marks one config_clock period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tg_cnt_q <= '0;
    else if (tick)
      tg_cnt_q <= '0;
    else
      tg_cnt_q <= tg_cnt_q + 1'b1;
  end

  assign tick = (tg_cnt_q == ($clog2(TG_DIV))'(TG_DIV - 1));

  // config clock rises at each tick, falls at half period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_clock_q <= 1'b0;
    else if (tick)
      config_clock_q <= 1'b1;
    else if (tg_cnt_q == ($clog2(TG_DIV))'(TG_DIV / 2 - 1))
      config_clock_q <= 1'b0;
  end

  // two flops before anything looks at the wired pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= done_program_pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // low must follow a seen high, so a pin still low after load is no request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev_q <= 1'b0;
      low_cnt_q <= 2'h0;
    end
    else if (tick)
    begin
      pin_prev_q <= pin_sync_q;
      if (pin_sync_q || state_q != rasc_pkg::ST_OPERATE)
        low_cnt_q <= 2'h0;
      else if (pin_prev_q || low_cnt_q != 2'h0)
        low_cnt_q <= (low_cnt_q == rasc_pkg::FILTER_TICKS) ? low_cnt_q : low_cnt_q + 2'h1;
    end
  end

  // noise shorter than one tick never reaches the sequencer
  assign req_ok = (low_cnt_q == rasc_pkg::FILTER_TICKS);

  assign step_d = step_q + 2'h1;

  // main reprogram and start-up sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= rasc_pkg::ST_CLEAR;
    else
      unique case (state_q)
        rasc_pkg::ST_OPERATE:
          if (req_ok)
            state_q <= rasc_pkg::ST_CLEAR;
        rasc_pkg::ST_CLEAR:
          if (tick && clr_cnt_q == ($clog2(CLEAR_TICKS+1))'(CLEAR_TICKS))
            state_q <= rasc_pkg::ST_WAIT_LOAD;
        rasc_pkg::ST_WAIT_LOAD:
          if (config_load_done)
            state_q <= rasc_pkg::ST_STARTUP;
        rasc_pkg::ST_STARTUP:
          // pin level is not consulted here, so a held request cannot stall us
          if (tick && step_d == rasc_pkg::STEP_LATE)
            state_q <= rasc_pkg::ST_OPERATE;
      endcase
  end

  // clear counter walks the whole memory in timing-generator ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_cnt_q <= '0;
    else if (state_q != rasc_pkg::ST_CLEAR)
      clr_cnt_q <= '0;
    else if (tick)
      clr_cnt_q <= clr_cnt_q + 1'b1;
  end

  // clear complete rises only after the last clear tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_done_q <= 1'b0;
    else
      clr_done_q <= (state_q == rasc_pkg::ST_WAIT_LOAD) ||
                    (state_q == rasc_pkg::ST_STARTUP);
  end

  // start-up step counter, restarted whenever load is pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_q <= 2'h0;
    else if (state_q != rasc_pkg::ST_STARTUP)
      step_q <= 2'h0;
    else if (tick && step_q != rasc_pkg::STEP_LATE)
      step_q <= step_d;
  end

  // outputs enable on the middle start-up step; pull-ups share this next value
  always_comb
  begin
    oe_d = oe_q;
    if (state_q == rasc_pkg::ST_OPERATE && !req_ok)
      oe_d = 1'b1;
    else if (state_q != rasc_pkg::ST_STARTUP)
      oe_d = 1'b0;
    else if (tick && step_d == rasc_pkg::STEP_OUTPUTS)
      oe_d = 1'b1;
  end

  // done one tick before or after the outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= 1'b0;
    else if (state_q == rasc_pkg::ST_OPERATE && !req_ok)
      done_q <= 1'b1;
    else if (state_q != rasc_pkg::ST_STARTUP)
      done_q <= 1'b0;
    else if (tick && step_d == (opts_q.done_early ? rasc_pkg::STEP_EARLY
                                                  : rasc_pkg::STEP_LATE))
      done_q <= 1'b1;
  end

  // internal reset keeps user flops at zero until its release step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_q <= 1'b1;
    else if (state_q == rasc_pkg::ST_OPERATE && !req_ok)
      rst_q <= 1'b0;
    else if (state_q != rasc_pkg::ST_STARTUP)
      rst_q <= 1'b1;
    else if (tick && step_d == (opts_q.reset_early ? rasc_pkg::STEP_EARLY
                                                   : rasc_pkg::STEP_LATE))
      rst_q <= 1'b0;
  end

  // crystal input is synchronised, then followed or halved
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      osc_prev_q <= 1'b0;
      osc_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_in;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
      // sampling limits the crystal to below half of pclk
      if (!opts_q.osc_div2)
        osc_q <= osc_sync_q;
      else if (osc_sync_q && !osc_prev_q)
        osc_q <= ~osc_q;
    end
  end

  // pin driver: only ever pulls low, never drives high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_program_pin_oe_n <= 1'b0;
    else
      done_program_pin_oe_n <= done_q & ~req_ok;
  end

  // registered copies of sequencer state and of the pull-up option for the outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_q <= 1'b0;
      done_pullup_en <= 1'b0;
      mem_clear <= 1'b1;
      io_pullup_en <= 1'b1;
    end
    else
    begin
      done_pullup_en <= opts_q.pullup_en;
      mem_clear <= (state_q == rasc_pkg::ST_CLEAR) && !(tick &&
                   clr_cnt_q == ($clog2(CLEAR_TICKS+1))'(CLEAR_TICKS));
      oe_q <= oe_d;
      // pull-ups follow the same edge as the outputs, so no pin floats a cycle
      io_pullup_en <= ~oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign done_program_pin_o = 1'b0;
  assign osc_out = osc_q;
  assign config_clock = config_clock_q;
  assign clear_complete_indication = clr_done_q;
  assign user_output_enable = oe_q;
  assign internal_reset = rst_q;

endmodule

// >>> hw/rasc_pkg.sv
package rasc_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_OPTIONS = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  // option register field positions
  localparam int OPT_PULLUP_BIT = 0;
  localparam int OPT_DONE_EARLY_BIT = 1;
  localparam int OPT_RESET_EARLY_BIT = 2;
  localparam int OPT_OSC_DIV2_BIT = 3;
  localparam logic [3:0] OPT_RESET = 4'h0;

  // timing generator and clear defaults, in pclk cycles or ticks
  localparam int TG_DIV_DEFAULT = 8;
  localparam int CLEAR_TICKS_DEFAULT = 64;
  localparam logic [1:0] FILTER_TICKS = 2'h2;

  // start-up steps, counted in config_clock ticks after load done
  localparam logic [1:0] STEP_EARLY = 2'h1;
  localparam logic [1:0] STEP_OUTPUTS = 2'h2;
  localparam logic [1:0] STEP_LATE = 2'h3;

  // start-up options fixed by configuration bits
  typedef struct packed {
    logic osc_div2;
    logic reset_early;
    logic done_early;
    logic pullup_en;
  } rasc_opts_t;

  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_WAIT_LOAD,
    ST_STARTUP,
    ST_OPERATE
  } rasc_state_t;

endpackage

// >>> hw/README_unused.sv
// intentionally empty

// >>> verification/rasc_ctrl_assertions.sv
module rasc_ctrl_assertions #(
  parameter int TG_DIV = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic done_program_pin_i,
  input wire logic done_program_pin_oe_n,
  input wire logic done_pullup_en,
  input wire logic mem_clear,
  input wire logic clear_complete_indication,
  input wire logic user_output_enable,
  input wire logic io_pullup_en,
  input wire logic internal_reset,
  input wire logic config_load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // one tick plus slack; start-up events sit one tick apart
  localparam int GAP = 12;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // one access cycle, then idle
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer late or long");
  a_apb_unmapped: assert property (pready && paddr[11:3] != 0 |-> pslverr)
    else $error("unmapped access not refused");
  a_pullup_opt: assert property (psel && pready && penable && pwrite && paddr == 12'h000
    |=> ##1 done_pullup_en == $past(pwdata[0], 2)) else $error("pull-up not per option");
  // a request needs a low that lasted over one tick
  a_filter_low: assert property ($fell(user_output_enable) |->
    !$past(done_program_pin_i, 2) && !$past(done_program_pin_i, TG_DIV))
    else $error("short low accepted");
  a_reprog_entry: assert property ($fell(user_output_enable) |->
    io_pullup_en && internal_reset && !done_program_pin_oe_n)
    else $error("reprogram entry wrong");
  a_clear_order: assert property ($rose(clear_complete_indication) |->
    !mem_clear && $past(mem_clear, 2)) else $error("init before clear");
  // load pending: clear running, or cleared and no load yet
  a_pin_held: assert property (mem_clear || clear_complete_indication && !config_load_done
    && !user_output_enable |-> !done_program_pin_oe_n) else $error("pin released early");
  a_hold_zero: assert property (mem_clear || clear_complete_indication && !config_load_done
    && !user_output_enable |-> internal_reset && !user_output_enable)
    else $error("user reset dropped");
  a_done_near: assert property ($rose(done_program_pin_oe_n) |->
    ##[0:GAP] user_output_enable) else $error("done far from outputs");
  a_out_done: assert property ($rose(user_output_enable) |->
    ##[0:GAP] done_program_pin_oe_n) else $error("done missing after outputs");
  a_reset_near: assert property ($fell(internal_reset) |->
    ##[0:GAP] user_output_enable) else $error("reset far from outputs");
  c_reprog: cover property ($fell(user_output_enable));
  c_load: cover property ($rose(user_output_enable));
  c_refuse: cover property (pready && pslverr);
endmodule

bind rasc_ctrl rasc_ctrl_assertions #(.TG_DIV(TG_DIV)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .done_program_pin_i, .done_program_pin_oe_n, .done_pullup_en, .mem_clear,
  .clear_complete_indication, .user_output_enable, .io_pullup_en, .internal_reset,
  .config_load_done
);

// >>> verification/rasc_pin_drv.sv
module rasc_pin_drv (
  input wire logic pull,
  input wire logic oe_n,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // board pull-up; low if the driver or the device pulls
  assign pin = !(pull || !oe_n);
endmodule

// >>> verification/rasc_ctrl_tb_top.sv
module rasc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pull, load_done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] oc;
  logic [3:0] mon;
  logic pready, pslverr, pin, oe_n, pu_en, osc_out, mclr, cdone, uoe, iopu, irst;
  int mismatches, checks;
  // short counts keep the run brief
  rasc_ctrl #(.TG_DIV(4), .CLEAR_TICKS(4)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .done_program_pin_i(pin), .done_program_pin_o(), .done_program_pin_oe_n(oe_n),
    .done_pullup_en(pu_en), .config_load_done(load_done), .osc_in(oc[3]), .osc_out,
    .config_clock(), .mem_clear(mclr), .clear_complete_indication(cdone),
    .user_output_enable(uoe), .io_pullup_en(iopu), .internal_reset(irst)
  );
  rasc_pin_drv u_pin (.pull, .oe_n, .pin);
  assign mon = {irst, uoe, cdone, oe_n};
  initial
  begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  // crystal at pclk/16
  always @(posedge pclk) oc <= oc + 4'h1;
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait on one watched line
  task automatic wait_for(input int k, input logic v);
    int i;
    for (i = 0; i < 400 && mon[k] !== v; i++) @(posedge pclk);
    if (mon[k] !== v)
    begin
      mismatches++;
      close_out();
    end
  endtask
  // one apb transfer, then two idle cycles so registered outputs settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // look between edges: the value seen is what the next edge samples
    for (i = 0; i < 20; i++)
    begin
      @(negedge pclk);
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (pready !== 1'b1)
    begin
      mismatches++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
  // count osc_out rises over four crystal periods
  task automatic osc_cnt(input logic [31:0] exp);
    logic p;
    int r;
    r = 0;
    p = osc_out;
    repeat (64)
    begin
      @(posedge pclk);
      if (osc_out && !p) r++;
      p = osc_out;
    end
    chk(r, exp);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, pull, load_done} = 0;
    paddr = 0;
    pwdata = 0;
    oc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, rasc_pkg::OFS_OPTIONS, 0);
    chk(rd, 0);
    apb(1, 12'h008, 32'h5);
    chk(err, 1);
    $display("test registers done");
    wait_for(1, 1);
    chk({mclr, oe_n, iopu, irst}, 4'h3);
    apb(1, rasc_pkg::OFS_OPTIONS, 32'hF);
    chk(pu_en, 1);
    load_done <= 1;
    wait_for(2, 1);
    chk({oe_n, irst}, 2'h2);
    load_done <= 0;
    osc_cnt(2);
    chk(pin, 1);
    $display("test early start-up done");
    pull <= 1;
    repeat (3) @(posedge pclk);
    pull <= 0;
    repeat (20) @(posedge pclk);
    chk(uoe, 1);
    $display("test glitch done");
    apb(1, rasc_pkg::OFS_OPTIONS, 0);
    chk(pu_en, 0);
    pull <= 1;
    wait_for(2, 0);
    chk({iopu, irst, oe_n}, 3'h6);
    wait_for(1, 1);
    load_done <= 1;
    wait_for(2, 1);
    chk({oe_n, irst}, 2'h1);
    repeat (12) @(posedge pclk);
    chk({oe_n, irst, uoe}, 3'h5);
    osc_cnt(4);
    $display("test late reprogram done");
    close_out();
  end
endmodule
